// >>> hdl/ptm_pkg.sv
// package: register map, field layout, reset values and types of the periodic timer
// Behaviour
// - Mode 11 runs as compare-match mode with the same flags, pin released.
// - Timer/counter mode releases the output pin for other use.
// - Mode 10 gives fixed-frequency PWM with programmable duty.
// - PWM: period match clears the counter; compare value sets the duty.
// - Period 1..1023 gives that many counts; period 0 gives 1024.
// - Duty value at or above period keeps PWM active all period.
// - PWM: each comparator match sets its own flag.
// - PWM: level bit picks active high/low; action passes PWM or forces pin.
// - Invert bit inverts the waveform on the output pin.
// - PWM counter keeps running while action forces the pin (00, 01).
// - Clear source select is ignored in PWM mode.
// - Single pulse: run rising starts counter and the pulse leading edge.
// - Single pulse: trigger pin active edge sets the run bit.
// - Single pulse: compare match or software clears run, ending the pulse.
// - Single pulse: compare match raises the compare flag.
// - Single pulse: counter returns to zero only on run rising edge.
// - Single pulse: period comparator and clear select have no effect.
// - Compare mode: run rising edge restores the pin to its initial level.
// - Compare mode, clear select 1: compare match clears; no period flag.
// - Compare mode: pin changes only on compare-value match or run rising edge.
// - Compare value zero: counter overflows at 3FF, no compare flag.
// - Compare mode action: 00 no change, 01 low, 10 high, 11 toggle.
// - Single pulse: level bit sets the pin level while run is high.
package ptm_pkg;
  localparam int          CNT_W       = 10;
  localparam int          SEL_W       = 3;
  // register byte offsets
  localparam logic [7:0]  OFF_CTRL0   = 8'h00;
  localparam logic [7:0]  OFF_CTRL1   = 8'h04;
  localparam logic [7:0]  OFF_COUNT   = 8'h08;
  localparam logic [7:0]  OFF_CMPA    = 8'h0c;
  localparam logic [7:0]  OFF_PERIOD  = 8'h10;
  localparam logic [7:0]  OFF_STATUS  = 8'h14;
  // timer control zero
  localparam int          C0_RUN      = 0;
  localparam int          C0_CKSEL    = 1;
  localparam int          C0_TRIGRISE = 4;
  // timer_ctrl_one
  localparam int          C1_CLRSEL   = 0;
  localparam int          C1_INVERT   = 2;
  localparam int          C1_LEVEL    = 3;
  localparam int          C1_ACTION   = 4;
  localparam int          C1_MODE     = 6;
  // status
  localparam int          ST_AFLAG    = 0;
  localparam int          ST_PFLAG    = 1;
  localparam int          ST_PIN      = 2;
  localparam int          ST_RUN      = 3;
  // reset values
  localparam logic [7:0]  CTRL0_RST   = 8'h00;
  localparam logic [7:0]  CTRL1_RST   = 8'h00;
  localparam logic [9:0]  CMPA_RST    = 10'h000;
  localparam logic [9:0]  PERIOD_RST  = 10'h000;
  localparam logic [10:0] FULL_PERIOD = 11'h400;

  typedef enum logic [1:0] {
    PTM_MODE_CMP  = 2'b00,
    PTM_MODE_RSVD = 2'b01,
    PTM_MODE_PWM  = 2'b10,
    PTM_MODE_TMR  = 2'b11
  } ptm_mode_t;

  typedef enum logic [1:0] {
    PTM_ACT_A = 2'b00,
    PTM_ACT_B = 2'b01,
    PTM_ACT_C = 2'b10,
    PTM_ACT_D = 2'b11
  } ptm_act_t;
endpackage

// >>> hdl/ptm_tick_if.sv
// interface: tick and trigger signals between timer core and helpers
`timescale 1ns/100ps
interface ptm_tick_if;
  logic [2:0] clkSel;
  logic       trigRise;
  logic       tick;
  logic       trigEvt;
  modport core  (output clkSel, output trigRise, input tick, input trigEvt);
  modport presc (input clkSel, output tick);
  modport edet  (input trigRise, output trigEvt);
endinterface

// >>> hdl/ptm_prescaler.sv
// module: timer clock prescaler, one-cycle tick every 2**clkSel clocks
`timescale 1ns/100ps
module ptm_prescaler
(
  input  logic     clock,   // system clock
  input  logic     nrst,    // async reset, low
  ptm_tick_if.presc tb      // select in, tick out
);
  typedef struct packed
  {
    logic [7:0] cnt;
    logic       tick;
  } ptm_presc_t;

  ptm_presc_t s;
  ptm_presc_t n;
  logic [7:0] mask;

  assign mask    = 8'((9'h001 << tb.clkSel) - 9'h001);
  assign tb.tick = s.tick;

  always_comb
  begin
    n      = s;
    n.cnt  = s.cnt + 8'h01;
    n.tick = ((s.cnt & mask) == mask);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= n;
  end
endmodule

// >>> hdl/ptm_edge_det.sv
// module: active-edge detector for the external trigger pin
`timescale 1ns/100ps
module ptm_edge_det
(
  input  logic    clock,         // system clock
  input  logic    nrst,          // async reset, low
  input  logic    extTriggerPin, // trigger pin, synchronous
  ptm_tick_if.edet tb            // edge select in, event out
);
  typedef struct packed
  {
    logic prev;
    logic evt;
  } ptm_edge_t;

  ptm_edge_t s;
  ptm_edge_t n;

  assign tb.trigEvt = s.evt;

  always_comb
  begin
    n      = s;
    n.prev = extTriggerPin;
    n.evt  = tb.trigRise ? (extTriggerPin & ~s.prev) : (~extTriggerPin & s.prev);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= n;
  end
endmodule

// >>> hdl/ptm_timer.sv
// module: periodic timer top, apb registers, counter, comparators, output pin
`timescale 1ns/100ps
module ptm_timer
(
  input  logic        clock,         // system clock, 25 MHz
  input  logic        nrst,          // async reset, low
  input  logic [7:0]  paddr,         // apb byte address
  input  logic        psel,          // apb select
  input  logic        penable,       // apb access phase
  input  logic        pwrite,        // apb direction, 1 write
  input  logic [31:0] pwdata,        // apb write data
  output logic [31:0] prdata,        // apb read data
  output logic        pready,        // apb ready, always high
  output logic        pslverr,       // apb error on unmapped address
  input  logic        extTriggerPin, // external trigger input
  output logic        outPin,        // output pin level
  output logic        outPinOeN,     // output enable, low drives
  output logic        cmpAEvt,       // compare-value match, one clock
  output logic        cmpPEvt,       // period match, one clock
  output logic        cmpAFlag,      // sticky compare-value flag
  output logic        cmpPFlag       // sticky period flag
);
  typedef struct packed
  {
    logic                 run;
    logic                 runQ;
    logic [2:0]           clkSel;
    logic                 trigRise;
    ptm_pkg::ptm_mode_t   mode;
    ptm_pkg::ptm_act_t    act;
    logic                 level;
    logic                 invert;
    logic                 clrSel;
    logic [9:0]           cmpA;
    logic [9:0]           period;
    logic [9:0]           cnt;
    logic                 cmpLevel;
    logic                 aFlag;
    logic                 pFlag;
    logic                 aEvt;
    logic                 pEvt;
    logic                 pin;
    logic                 pinOeN;
    logic [31:0]          rdata;
    logic                 slvErr;
  } ptm_state_t;

  ptm_state_t s;
  ptm_state_t n;

  ptm_tick_if tb ();

  ptm_prescaler u_presc
  (
    .clock (clock),
    .nrst  (nrst),
    .tb    (tb)
  );

  ptm_edge_det u_edge
  (
    .clock         (clock),
    .nrst          (nrst),
    .extTriggerPin (extTriggerPin),
    .tb            (tb)
  );

  assign tb.clkSel   = s.clkSel;
  assign tb.trigRise = s.trigRise;

  // bus decode
  logic        setup;
  logic        wrAcc;
  logic        mapped;
  logic [31:0] rdMux;

  assign setup  = psel & ~penable;
  assign wrAcc  = psel & penable & pwrite;
  assign mapped = (paddr == ptm_pkg::OFF_CTRL0) || (paddr == ptm_pkg::OFF_CTRL1) ||
                  (paddr == ptm_pkg::OFF_COUNT) || (paddr == ptm_pkg::OFF_CMPA) ||
                  (paddr == ptm_pkg::OFF_PERIOD) || (paddr == ptm_pkg::OFF_STATUS);

  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      ptm_pkg::OFF_CTRL0:
      begin
        rdMux[ptm_pkg::C0_RUN]                 = s.run;
        rdMux[ptm_pkg::C0_CKSEL +: 3]          = s.clkSel;
        rdMux[ptm_pkg::C0_TRIGRISE]            = s.trigRise;
      end
      ptm_pkg::OFF_CTRL1:
      begin
        rdMux[ptm_pkg::C1_CLRSEL]              = s.clrSel;
        rdMux[ptm_pkg::C1_INVERT]              = s.invert;
        rdMux[ptm_pkg::C1_LEVEL]               = s.level;
        rdMux[ptm_pkg::C1_ACTION +: 2]         = s.act;
        rdMux[ptm_pkg::C1_MODE +: 2]           = s.mode;
      end
      ptm_pkg::OFF_COUNT:  rdMux[9:0] = s.cnt;
      ptm_pkg::OFF_CMPA:   rdMux[9:0] = s.cmpA;
      ptm_pkg::OFF_PERIOD: rdMux[9:0] = s.period;
      ptm_pkg::OFF_STATUS:
      begin
        rdMux[ptm_pkg::ST_AFLAG]               = s.aFlag;
        rdMux[ptm_pkg::ST_PFLAG]               = s.pFlag;
        rdMux[ptm_pkg::ST_PIN]                 = s.pin;
        rdMux[ptm_pkg::ST_RUN]                 = s.run;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // comparators
  logic        runRise;
  logic        spMode;
  logic        aHit;
  logic        pHit;
  logic [9:0]  cntInc;
  logic [10:0] perFull;
  logic        pwmActive;
  logic        pwmLvl;

  assign runRise = s.run & ~s.runQ;
  assign spMode  = (s.mode == ptm_pkg::PTM_MODE_PWM) && (s.act == ptm_pkg::PTM_ACT_D);
  assign cntInc  = s.cnt + 10'h001;
  // a zero compare value never matches, so the counter wraps at 3ff
  assign aHit    = (s.cmpA != 10'h000) && (cntInc == s.cmpA);
  // period zero: the last count is 3ff, giving 1024 counts
  assign pHit    = (cntInc == s.period);
  assign perFull = (s.period == 10'h000) ? ptm_pkg::FULL_PERIOD : {1'b0, s.period};
  assign pwmActive = ({1'b0, s.cmpA} >= perFull) || (s.cnt < s.cmpA);
  assign pwmLvl  = s.level ? pwmActive : ~pwmActive;

  always_comb
  begin
    n      = s;
    n.aEvt = 1'b0;
    n.pEvt = 1'b0;
    n.runQ = s.run;

    // counter and comparator events
    if (runRise)
    begin
      n.cnt      = 10'h000;
      n.cmpLevel = s.level;
    end
    else if (s.run && tb.tick)
    begin
      unique case (s.mode)
        ptm_pkg::PTM_MODE_PWM:
        begin
          if (spMode)
          begin
            // no clear here: only a run rising edge restarts from zero
            n.cnt  = cntInc;
            n.aEvt = aHit;
          end
          else
          begin
            n.aEvt = aHit;
            n.pEvt = pHit;
            n.cnt  = pHit ? 10'h000 : cntInc;
          end
        end
        default:
        begin
          n.aEvt = aHit;
          if (s.clrSel)
            n.cnt = aHit ? 10'h000 : cntInc;
          else
          begin
            n.pEvt = pHit;
            n.cnt  = pHit ? 10'h000 : cntInc;
          end
          if (aHit && s.mode == ptm_pkg::PTM_MODE_CMP)
          begin
            unique case (s.act)
              ptm_pkg::PTM_ACT_A: n.cmpLevel = s.cmpLevel;
              ptm_pkg::PTM_ACT_B: n.cmpLevel = 1'b0;
              ptm_pkg::PTM_ACT_C: n.cmpLevel = 1'b1;
              ptm_pkg::PTM_ACT_D: n.cmpLevel = ~s.cmpLevel;
            endcase
          end
        end
      endcase
    end

    // apb read data and error are captured in the setup cycle
    if (setup)
    begin
      n.rdata  = pwrite ? 32'h0000_0000 : rdMux;
      n.slvErr = ~mapped;
    end

    // register writes
    if (wrAcc)
    begin
      unique case (paddr)
        ptm_pkg::OFF_CTRL0:
        begin
          n.run      = pwdata[ptm_pkg::C0_RUN];
          n.clkSel   = pwdata[ptm_pkg::C0_CKSEL +: 3];
          n.trigRise = pwdata[ptm_pkg::C0_TRIGRISE];
        end
        ptm_pkg::OFF_CTRL1:
        begin
          n.clrSel = pwdata[ptm_pkg::C1_CLRSEL];
          n.invert = pwdata[ptm_pkg::C1_INVERT];
          n.level  = pwdata[ptm_pkg::C1_LEVEL];
          n.act    = ptm_pkg::ptm_act_t'(pwdata[ptm_pkg::C1_ACTION +: 2]);
          n.mode   = ptm_pkg::ptm_mode_t'(pwdata[ptm_pkg::C1_MODE +: 2]);
        end
        ptm_pkg::OFF_CMPA:   n.cmpA   = pwdata[9:0];
        ptm_pkg::OFF_PERIOD: n.period = pwdata[9:0];
        ptm_pkg::OFF_STATUS:
        begin
          // write one to clear
          if (pwdata[ptm_pkg::ST_AFLAG])
            n.aFlag = 1'b0;
          if (pwdata[ptm_pkg::ST_PFLAG])
            n.pFlag = 1'b0;
        end
        default: n.run = n.run;
      endcase
    end

    // hardware run control after software, so the trigger set wins
    if (spMode && n.aEvt)
      n.run = 1'b0;
    if (spMode && tb.trigEvt)
      n.run = 1'b1;

    // sticky flags: a new event beats a clear in the same cycle
    if (n.aEvt)
      n.aFlag = 1'b1;
    if (n.pEvt)
      n.pFlag = 1'b1;

    // output pin
    n.pinOeN = 1'b0;
    unique case (s.mode)
      ptm_pkg::PTM_MODE_CMP:
        n.pin = s.cmpLevel ^ s.invert;
      ptm_pkg::PTM_MODE_PWM:
      begin
        unique case (s.act)
          ptm_pkg::PTM_ACT_A: n.pin = 1'b0 ^ s.invert;
          ptm_pkg::PTM_ACT_B: n.pin = 1'b1 ^ s.invert;
          ptm_pkg::PTM_ACT_C: n.pin = pwmLvl ^ s.invert;
          ptm_pkg::PTM_ACT_D: n.pin = (s.run ? s.level : ~s.level) ^ s.invert;
        endcase
      end
      default:
      begin
        // released so the pin can serve another function
        n.pin    = 1'b0;
        n.pinOeN = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s          <= '0;
      s.clkSel   <= ptm_pkg::CTRL0_RST[ptm_pkg::C0_CKSEL +: 3];
      s.mode     <= ptm_pkg::PTM_MODE_CMP;
      s.act      <= ptm_pkg::PTM_ACT_A;
      s.cmpA     <= ptm_pkg::CMPA_RST;
      s.period   <= ptm_pkg::PERIOD_RST;
      s.pinOeN   <= 1'b1;
    end
    else
      s <= n;
  end

  assign prdata    = s.rdata;
  assign pready    = 1'b1;
  assign pslverr   = s.slvErr & psel & penable;
  assign outPin    = s.pin;
  assign outPinOeN = s.pinOeN;
  assign cmpAEvt   = s.aEvt;
  assign cmpPEvt   = s.pEvt;
  assign cmpAFlag  = s.aFlag;
  assign cmpPFlag  = s.pFlag;
endmodule

// >>> testbench/ptm_timer_props.sv
// checker: port-level properties of the periodic timer
`timescale 1ns/100ps
module ptm_timer_props
(
  input logic        clock,     // system clock
  input logic        nrst,      // async reset, low
  input logic [7:0]  paddr,     // apb address
  input logic        psel,      // apb select
  input logic        penable,   // apb access phase
  input logic        pwrite,    // apb direction
  input logic [31:0] pwdata,    // apb write data
  input logic        outPin,    // pin level
  input logic        outPinOeN, // pin enable, low drives
  input logic        cmpAEvt,   // compare event
  input logic        cmpPEvt,   // period event
  input logic        cmpAFlag   // compare flag
);
  typedef struct packed {logic [7:0] c1;} ptm_shadow_t;
  ptm_shadow_t sh;
  ptm_shadow_t next_sh;
  logic        wrEn;
  logic        stClr;
  logic        spMode;
  assign wrEn   = psel && penable && pwrite;
  assign stClr  = wrEn && paddr == ptm_pkg::OFF_STATUS && pwdata[0];
  assign spMode = sh.c1[7:6] == 2'b10 && sh.c1[5:4] == 2'b11;
  // shadow of the mode byte, so properties know which mode is live
  always_comb
  begin
    next_sh = sh;
    if (wrEn && paddr == ptm_pkg::OFF_CTRL1)
      next_sh.c1 = pwdata[7:0];
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sh <= '0;
    else
      sh <= next_sh;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // pin settles at the idle level within two clocks of the ending match
  sequence spIdle;
    ##[0:2] outPin == (!sh.c1[3] ^ sh.c1[2]);
  endsequence
  AST_AEVT_ONE: assert property (cmpAEvt |=> !cmpAEvt)
    else $error("compare event longer than one clock");
  AST_PEVT_ONE: assert property (cmpPEvt |=> !cmpPEvt)
    else $error("period event longer than one clock");
  AST_AFLAG_SET: assert property (cmpAEvt |-> cmpAFlag)
    else $error("compare flag not set with its event");
  AST_AFLAG_HOLD: assert property ($fell(cmpAFlag) |-> $past(stClr))
    else $error("compare flag dropped without a clear");
  AST_TMR_FREE: assert property ((sh.c1[7:6] == 2'b11) [*3] |-> outPinOeN)
    else $error("pin driven in timer mode");
  AST_PWM_DRIVE: assert property ((sh.c1[7:6] == 2'b10) [*3] |-> !outPinOeN)
    else $error("pin not driven in pwm mode");
  AST_CLR_NO_P: assert property ((sh.c1[7:6] == 2'b00 && sh.c1[0]) [*3] |-> !cmpPEvt)
    else $error("period event with compare clearing");
  AST_SP_END: assert property (spMode && cmpAEvt |-> spIdle)
    else $error("single pulse not ended by compare match");
endmodule

// >>> testbench/ptm_ext_model.sv
// partner: load on the output pin and source of the trigger pin
`timescale 1ns/100ps
module ptm_ext_model
(
  input  logic clock,     // system clock
  input  logic fire,      // bench request for one trigger pulse
  input  logic outPin,    // pin level from the timer
  input  logic outPinOeN, // pin enable, low drives
  output logic trigPin,   // trigger pin, idle low
  output logic pinWire    // resolved pin level
);
  logic [1:0] hold = 2'h0;
  // a released pin sits on the load's pull-down
  assign pinWire = outPinOeN ? 1'b0 : outPin;
  // trigger held three clocks so a synchronous edge detector cannot miss it
  always @(posedge clock)
  begin
    if (fire)
      hold <= 2'h3;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
  end
  assign trigPin = hold != 2'h0;
endmodule

// >>> testbench/ptm_timer_bench.sv
// bench: apb-driven tests of the periodic timer
`timescale 1ns/100ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %0t: got %0h exp %0h", $time, (g), (e)); end end
module ptm_timer_bench;
  logic        clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, fire = 1'b0, err, last;
  logic [7:0]  paddr = 8'h00, c;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, trig, outPin, outPinOeN, pinWire;
  logic        cmpAEvt, cmpPEvt, cmpAFlag, cmpPFlag;
  int          mismatches = 0, nTests = 0;
  int          i, k, np, nh, na, npe, nc, ex, w5, w9, w;
  int          pv[8] = '{5, 0, 4, 6, 6, 6, 6, 6};
  int          av[8] = '{2, 3, 6, 2, 2, 2, 2, 2};
  logic [7:0]  c1v[8] = '{8'ha9, 8'ha8, 8'ha8, 8'ha0, 8'hac, 8'h88, 8'h98, 8'h8c};
  always #20 clock = ~clock;
  ptm_timer ptm_timer_i (.clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extTriggerPin(trig), .outPin(outPin),
    .outPinOeN(outPinOeN), .cmpAEvt(cmpAEvt), .cmpPEvt(cmpPEvt),
    .cmpAFlag(cmpAFlag), .cmpPFlag(cmpPFlag));
  ptm_ext_model ptm_ext_model_i (.clock(clock), .fire(fire), .outPin(outPin),
    .outPinOeN(outPinOeN), .trigPin(trig), .pinWire(pinWire));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic measure(output int p, output int h);
    @(negedge clock);
    for (k = 0; k < 3000 && cmpPEvt !== 1'b1; k++) @(negedge clock);
    p = 0;
    h = 0;
    do
    begin
      @(negedge clock);
      p++;
      h += pinWire;
    end while (cmpPEvt !== 1'b1 && p < 3000);
  endtask
  task automatic pulse(output int n);
    n = 0;
    repeat (40)
    begin
      @(negedge clock);
      n += pinWire;
    end
  endtask
  // high clocks in one period, from period, duty and the pin control bits
  function automatic int exp_high(int p, int a, logic [7:0] m);
    int pp, d, r;
    pp = (p == 0) ? 1024 : p;
    d  = (a >= pp) ? pp : a;
    case (m[5:4])
      2'b00:   r = 0;
      2'b01:   r = pp;
      default: r = m[3] ? d : pp - d;
    endcase
    return m[2] ? pp - r : r;
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #(40 * 20000);
    mismatches++;
    $display("CHECK FAILED %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    apb(1'b0, ptm_pkg::OFF_CTRL1, 0);
    `CHK(rd[7:0], ptm_pkg::CTRL1_RST)
    apb(1'b1, ptm_pkg::OFF_CMPA, 32'hffff_ffff);
    apb(1'b0, ptm_pkg::OFF_CMPA, 0);
    `CHK(rd, 32'h0000_03ff)
    apb(1'b0, 8'h18, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    $display("test registers done");
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, ptm_pkg::OFF_CTRL1, {24'h0, c1v[i]});
      apb(1'b1, ptm_pkg::OFF_CMPA, av[i]);
      apb(1'b1, ptm_pkg::OFF_PERIOD, pv[i]);
      apb(1'b1, ptm_pkg::OFF_CTRL0, 32'h1);
      measure(np, nh);
      `CHK(np, pv[i] == 0 ? 1024 : pv[i])
      `CHK(nh, exp_high(pv[i], av[i], c1v[i]))
      apb(1'b1, ptm_pkg::OFF_CTRL0, 0);
      apb(1'b0, ptm_pkg::OFF_STATUS, 0);
      `CHK(rd[1:0], {1'b1, av[i] < (pv[i] == 0 ? 1024 : pv[i])})
      `CHK(cmpPFlag, 1'b1)
      apb(1'b1, ptm_pkg::OFF_STATUS, 3);
    end
    $display("test pwm done");
    for (i = 0; i < 6; i++)
    begin
      c = (i == 5) ? 8'h71 : (i == 4) ? 8'hf1 : {2'b00, i[1:0], i == 1, 3'b001};
      apb(1'b1, ptm_pkg::OFF_PERIOD, 2);
      apb(1'b1, ptm_pkg::OFF_CMPA, 3);
      apb(1'b1, ptm_pkg::OFF_CTRL1, {24'h0, c});
      apb(1'b1, ptm_pkg::OFF_CTRL0, 32'h7);
      repeat (4) @(negedge clock);
      `CHK(pinWire, i == 1)
      `CHK(outPinOeN, i >= 4)
      na = 0;
      npe = 0;
      nc = 0;
      ex = 0;
      last = pinWire;
      for (k = 0; k < 400 && ex < 3; k++)
      begin
        @(negedge clock);
        nc += (pinWire !== last);
        last = pinWire;
        if (na < 4)
        begin
          na += cmpAEvt;
          npe += cmpPEvt;
        end
        else
          ex++;
      end
      `CHK(na, 4)
      `CHK(npe, 0)
      `CHK(nc, (i == 3) ? 4 : (i == 1 || i == 2) ? 1 : 0)
      apb(1'b1, ptm_pkg::OFF_CTRL0, 0);
      apb(1'b1, ptm_pkg::OFF_STATUS, 3);
    end
    apb(1'b1, ptm_pkg::OFF_CMPA, 0);
    apb(1'b1, ptm_pkg::OFF_CTRL1, 32'h31);
    apb(1'b1, ptm_pkg::OFF_CTRL0, 32'h1);
    repeat (1100) @(negedge clock);
    apb(1'b0, ptm_pkg::OFF_STATUS, 0);
    `CHK(rd[2:0], 3'h0)
    apb(1'b1, ptm_pkg::OFF_CTRL0, 0);
    $display("test compare done");
    apb(1'b1, ptm_pkg::OFF_CMPA, 5);
    apb(1'b1, ptm_pkg::OFF_CTRL1, 32'hb8);
    apb(1'b1, ptm_pkg::OFF_CTRL0, 32'h10);
    @(posedge clock) fire <= 1'b1;
    @(posedge clock) fire <= 1'b0;
    pulse(w5);
    `CHK(w5 > 0, 1'b1)
    apb(1'b0, ptm_pkg::OFF_STATUS, 0);
    `CHK(rd[3:0], 4'h1)
    apb(1'b1, ptm_pkg::OFF_STATUS, 3);
    apb(1'b1, ptm_pkg::OFF_CMPA, 9);
    apb(1'b1, ptm_pkg::OFF_CTRL0, 32'h11);
    pulse(w9);
    `CHK(w9 - w5, 4)
    apb(1'b1, ptm_pkg::OFF_CMPA, 5);
    apb(1'b1, ptm_pkg::OFF_CTRL0, 32'h11);
    pulse(w);
    `CHK(w, w5)
    apb(1'b1, ptm_pkg::OFF_CMPA, 20);
    apb(1'b1, ptm_pkg::OFF_CTRL0, 32'h11);
    apb(1'b1, ptm_pkg::OFF_CTRL0, 32'h10);
    pulse(w);
    `CHK(w < w5, 1'b1)
    apb(1'b1, ptm_pkg::OFF_CMPA, 5);
    apb(1'b1, ptm_pkg::OFF_CTRL0, 0);
    @(posedge clock) fire <= 1'b1;
    @(posedge clock) fire <= 1'b0;
    pulse(w);
    `CHK(w, w5)
    $display("test single pulse done");
    report_and_stop();
  end
endmodule
bind ptm_timer ptm_timer_props ptm_timer_props_i (.clock(clock), .nrst(nrst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .outPin(outPin), .outPinOeN(outPinOeN), .cmpAEvt(cmpAEvt), .cmpPEvt(cmpPEvt),
  .cmpAFlag(cmpAFlag));
